// ### shared/vpbm_cfg.svh
// constants for the vector priority and boot map block
`ifndef VPBM_CFG_SVH
`define VPBM_CFG_SVH
// ****************************************
// vector table
// ****************************************
`define VPBM_NUM_VEC 22
`define VPBM_VEC_W 5
`define VPBM_ADDR_W 21
`define VPBM_LVL_W 2
`define VPBM_VEC_STRIDE_SHIFT 1
`define VPBM_FIXED_LVL 2'h3
`define VPBM_DBG_LVL_MIN 2'h1
`define VPBM_EXT_LVL_MAX 2'h2
// ****************************************
// boot addresses
// ****************************************
`define VPBM_BOOT_INT_RST 21'h020000
`define VPBM_BOOT_INT_WDT 21'h020002
`define VPBM_BOOT_EXT_RST 21'h000000
`define VPBM_BOOT_EXT_WDT 21'h000002
`define VPBM_BOOT_FLASH_LO 21'h020000
`define VPBM_BOOT_FLASH_HI 21'h020FFF
`define VPBM_FLASH_LO_BASE 21'h000000
`define VPBM_FLASH_HI_BASE 21'h010000
`define VPBM_FLASH_SIZE 21'h010000
`define VPBM_ADDR16_TOP 21'h00FFFF
`define VPBM_EXT_HI_BASE 21'h100000
`endif

// ### shared/vpbm_pkg.sv
// types for the vector priority and boot map block
package vpbm_pkg;
  typedef struct packed {
    logic valid;
    logic [4:0] vector;
    logic [1:0] level;
  } vpbm_cand_type;
  typedef struct packed {
    logic map_select_bit;
    logic secured_state_bit;
    logic address_width_strap;
  } vpbm_mode_type;
  typedef enum logic [2:0] {
    VPBM_INT_MAP = 3'h1,
    VPBM_EXT16_MAP = 3'h2,
    VPBM_EXT20_MAP = 3'h4
  } vpbm_map_type;
endpackage

// ### hw/vpbm_rank.sv
// one rank stage comparing two interrupt candidates
`timescale 1ns/1ps
module vpbm_rank
  import vpbm_pkg::*;
(
  input wire vpbm_cand_type cand_a,
  input wire vpbm_cand_type cand_b,
  output vpbm_cand_type winner
);
  // higher level wins, equal level keeps smaller vector (a is always lower)
  wire b_beats = cand_b.valid & (~cand_a.valid | (cand_b.level > cand_a.level));
  assign winner = b_beats ? cand_b : cand_a;
endmodule // vpbm_rank

// ### hw/vpbm_top.sv
// interrupt vector ranking and reset program map selection
// Behaviour
// RQ1: higher priority level serviced before lower
// RQ2: same level, smallest vector number wins
// RQ3: vector address is base plus two words
// RQ4: core exception vectors 2-5 fixed level 3
// RQ5: debug unit vectors take level 1-3
// RQ6: external, low voltage, pll take 0-2
// RQ7: reset fetches may overlay vector slots 0,1
// RQ8: software puts jumps then calls in table
// RQ9: internal boot fetches 020000 / 020002
// RQ10: external 16-bit boot fetches 000000 / 000002
// RQ11: external boot relocates program flash upward
// RQ12: external 20-bit boot uses ram at bootflash
// RQ13: width strap selects 16 or 20 bits
// RQ14: external above 00FFFF blocked until pins reconfigured
// RQ15: software configures pins before 100000 access
// RQ16: secured flash refuses external boot mode
// RQ17: map bit writable only if unsecured at reset
// RQ18: reset loads map and secured bits
// RQ19: present best unmasked vector every cycle
`timescale 1ns/1ps
`include "vpbm_cfg.svh"
module vpbm_top
  import vpbm_pkg::*;
#(
  parameter int NUM_VEC = `VPBM_NUM_VEC,
  parameter int ADDR_W = `VPBM_ADDR_W
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic external_boot_strap,
  input wire logic address_width_strap,
  input wire logic flash_secure,
  input wire logic watchdog_reset,
  input wire logic map_select_wr,
  input wire logic map_select_wdata,
  input wire logic upper_pins_enabled,
  input wire logic [ADDR_W-1:0] vector_base_register,
  input wire logic [NUM_VEC-1:0] irq_pending,
  input wire logic [2*NUM_VEC-1:0] irq_level_cfg,
  input wire logic [1:0] core_mask_level,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic [ADDR_W-1:0] boot_fetch_addr,
  output logic irq_valid,
  output logic [4:0] irq_vector,
  output logic [1:0] irq_level,
  output logic [ADDR_W-1:0] irq_vector_addr,
  output vpbm_mode_type mode_status,
  output vpbm_map_type map_state,
  output logic ext_addr_20bit,
  output logic fetch_external,
  output logic fetch_blocked,
  output logic [ADDR_W-1:0] flash_phys_addr,
  output logic flash_hit
);
  // ****************************************
  // operating mode bits
  // ****************************************
  logic map_q, map_d;
  logic secured_q;
  logic width_q;
  logic rst_seen_q;

  // first cycle after reset: capture straps in a clocked way
  wire load_straps = ~rst_seen_q;
  wire strap_map = external_boot_strap & ~flash_secure; // RQ16 RQ18
  assign map_d = load_straps ? strap_map :
                 (map_select_wr & ~secured_q) ? map_select_wdata : map_q; // RQ17

  // mode register process
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_seen_q <= 1'b0;
      map_q <= 1'b0;
      secured_q <= 1'b1;
      width_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
      map_q <= map_d;
      if (load_straps) begin
        secured_q <= flash_secure; // RQ18
        width_q <= address_width_strap; // RQ13
      end
    end
  end

  assign mode_status = '{map_select_bit: map_q, secured_state_bit: secured_q, address_width_strap: width_q};
  assign ext_addr_20bit = width_q; // RQ13

  // ****************************************
  // program map
  // ****************************************
  wire ext_map = map_q;
  wire ext20 = ext_map & width_q;
  assign map_state = !ext_map ? VPBM_INT_MAP : (ext20 ? VPBM_EXT20_MAP : VPBM_EXT16_MAP);

  // reset fetch address selection
  wire [ADDR_W-1:0] int_boot = watchdog_reset ? `VPBM_BOOT_INT_WDT : `VPBM_BOOT_INT_RST; // RQ9
  wire [ADDR_W-1:0] ext_boot = watchdog_reset ? `VPBM_BOOT_EXT_WDT : `VPBM_BOOT_EXT_RST; // RQ10
  // 20-bit external boot reuses the boot flash address, served from external ram
  wire [ADDR_W-1:0] boot_d = (ext_map & ~width_q) ? ext_boot : int_boot; // RQ12 RQ7

  // address decode for core fetches
  wire in_boot_win = (fetch_addr >= `VPBM_BOOT_FLASH_LO) && (fetch_addr <= `VPBM_BOOT_FLASH_HI);
  wire [ADDR_W-1:0] flash_base = ext_map ? `VPBM_FLASH_HI_BASE : `VPBM_FLASH_LO_BASE; // RQ11
  wire in_flash = (fetch_addr >= flash_base) && (fetch_addr < (flash_base + `VPBM_FLASH_SIZE));
  wire in_low_ext = ext_map & ~width_q & (fetch_addr <= `VPBM_ADDR16_TOP);
  wire in_boot_ext = ext20 & in_boot_win; // RQ12
  wire above_16 = fetch_addr > `VPBM_ADDR16_TOP;
  wire in_high_ext = fetch_addr >= `VPBM_EXT_HI_BASE;
  wire low_ext_int = ~ext_map & (fetch_addr >= `VPBM_FLASH_HI_BASE) & (fetch_addr < `VPBM_BOOT_FLASH_LO);
  wire ext_d = in_low_ext | in_boot_ext | in_high_ext | low_ext_int;
  // external space above the low 64K is unreachable until pins are reconfigured
  wire blocked_d = ext_d & above_16 & ~upper_pins_enabled; // RQ14 RQ15

  // ****************************************
  // interrupt level assignment
  // ****************************************
  logic [1:0] eff_lvl [NUM_VEC];
  vpbm_cand_type cand [NUM_VEC];

  // clamp programmed levels of debug and external vectors into their legal range; all other vectors take fixed levels
  generate
    for (genvar v = 0; v < NUM_VEC; v++) begin : g_lvl
      wire [1:0] raw = irq_level_cfg[2*v +: 2];
      wire fixed3 = (v >= 2) && (v <= 5);
      wire dbg = (v == 6) || (v == 7) || (v == 9) || (v == 10) || (v == 11);
      wire extl = (v == 17) || (v == 18) || (v == 20) || (v == 21);
      wire resv = (v <= 1) || (v == 8) || (v == 12) || (v == 13) || (v == 19);
      wire [1:0] sw_lvl = (v == 14) ? 2'h2 : (v == 15) ? 2'h1 : 2'h0;
      assign eff_lvl[v] = fixed3 ? `VPBM_FIXED_LVL : // RQ4
                          dbg ? ((raw < `VPBM_DBG_LVL_MIN) ? `VPBM_DBG_LVL_MIN : raw) : // RQ5
                          extl ? ((raw > `VPBM_EXT_LVL_MAX) ? `VPBM_EXT_LVL_MAX : raw) : // RQ6
                          sw_lvl;
      // masked requests below the core level are dropped
      assign cand[v] = '{valid: irq_pending[v] & ~resv & (eff_lvl[v] >= core_mask_level), // RQ19
                         vector: 5'(v), level: eff_lvl[v]};
    end
  endgenerate

  // ****************************************
  // ranking chain
  // ****************************************
  vpbm_cand_type chain [NUM_VEC];
  assign chain[0] = cand[0];
  generate
    for (genvar r = 1; r < NUM_VEC; r++) begin : g_rank
      // lower index kept on ties
      vpbm_rank u_rank (
        .cand_a(chain[r-1]),
        .cand_b(cand[r]),
        .winner(chain[r])
      ); // RQ1 RQ2
    end
  endgenerate

  wire vpbm_cand_type best = chain[NUM_VEC-1];
  // two words per vector
  wire [ADDR_W-1:0] vec_off = ADDR_W'({best.vector, 1'b0}); // RQ3
  wire [ADDR_W-1:0] vec_addr_d = vector_base_register + vec_off; // RQ3

  // ****************************************
  // output registers
  // ****************************************
  // remapped flash address seen by the flash array
  wire [ADDR_W-1:0] flash_off = fetch_addr - flash_base;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_valid <= 1'b0;
      irq_vector <= 5'h0;
      irq_level <= 2'h0;
      irq_vector_addr <= '0;
      boot_fetch_addr <= `VPBM_BOOT_INT_RST;
      fetch_external <= 1'b0;
      fetch_blocked <= 1'b0;
      flash_phys_addr <= '0;
      flash_hit <= 1'b0;
    end else begin
      irq_valid <= best.valid; // RQ19
      irq_vector <= best.vector;
      irq_level <= best.level;
      irq_vector_addr <= vec_addr_d;
      boot_fetch_addr <= boot_d;
      fetch_external <= ext_d;
      fetch_blocked <= blocked_d; // RQ14
      flash_phys_addr <= in_flash ? flash_off : '0;
      flash_hit <= in_flash; // RQ11
    end
  end
endmodule // vpbm_top

// ### testbench/vpbm_chk.sv
// assertions on the vector priority and boot map ports
`timescale 1ns/1ps
module vpbm_chk
  import vpbm_pkg::*;
#(
  parameter int NUM_VEC = 22,
  parameter int ADDR_W = 21
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic upper_pins_enabled,
  input wire logic [ADDR_W-1:0] vector_base_register,
  input wire logic [1:0] core_mask_level,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic irq_valid,
  input wire logic [4:0] irq_vector,
  input wire logic [1:0] irq_level,
  input wire logic [ADDR_W-1:0] irq_vector_addr,
  input wire vpbm_mode_type mode_status,
  input wire vpbm_map_type map_state,
  input wire logic ext_addr_20bit,
  input wire logic fetch_blocked,
  input wire logic fetch_external
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_vec_addr: assert property (irq_valid |-> irq_vector_addr == $past(vector_base_register)
    + (ADDR_W'(irq_vector) << 1)) else $error("vector address wrong");
  chk_fixed_lvl: assert property (irq_valid && irq_vector inside {[2:5]} |-> irq_level == 2'h3)
    else $error("core exception level wrong");
  chk_dbg_lvl: assert property (irq_valid && irq_vector inside {6, 7, 9, 10, 11} |-> irq_level != 2'h0)
    else $error("debug vector level wrong");
  chk_ext_lvl: assert property (irq_valid && irq_vector inside {17, 18, 20, 21} |-> irq_level != 2'h3)
    else $error("external vector level wrong");
  chk_mask_lvl: assert property (irq_valid |-> irq_level >= $past(core_mask_level))
    else $error("masked request granted");
  chk_rsvd_slot: assert property (irq_valid |-> !(irq_vector inside {0, 1, 8, 12, 13, 19}))
    else $error("reserved vector granted");
  chk_fetch_block: assert property (fetch_blocked |-> fetch_external && !$past(upper_pins_enabled)
    && $past(fetch_addr) > 21'h00FFFF) else $error("fetch blocked wrongly");
  chk_map_dec: assert property (map_state == (!mode_status.map_select_bit ? VPBM_INT_MAP :
    mode_status.address_width_strap ? VPBM_EXT20_MAP : VPBM_EXT16_MAP)) else $error("map decode wrong");
  chk_wide_bus: assert property (map_state == VPBM_EXT20_MAP |-> ext_addr_20bit)
    else $error("bus width wrong");
endmodule // vpbm_chk
bind vpbm_top vpbm_chk #(.NUM_VEC(NUM_VEC), .ADDR_W(ADDR_W)) i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .upper_pins_enabled(upper_pins_enabled), .vector_base_register(vector_base_register),
  .core_mask_level(core_mask_level), .fetch_addr(fetch_addr), .irq_valid(irq_valid), .irq_vector(irq_vector),
  .irq_level(irq_level), .irq_vector_addr(irq_vector_addr), .mode_status(mode_status), .map_state(map_state),
  .ext_addr_20bit(ext_addr_20bit), .fetch_blocked(fetch_blocked), .fetch_external(fetch_external));

// ### testbench/vpbm_core_model.sv
// processor core model fetching program and vector addresses
`timescale 1ns/1ps
module vpbm_core_model (
  input wire logic sys_clk,
  input wire logic take_vec,
  input wire logic irq_valid,
  input wire logic [20:0] irq_vector_addr,
  input wire logic [20:0] req_addr,
  output logic [20:0] fetch_addr
);
  // fetch the granted vector when asked, else the program address
  // slots 0 and 1 hold jumps, all other slots hold calls: only the slot address is fetched here
  always_ff @(posedge sys_clk) begin
    fetch_addr <= (take_vec && irq_valid) ? irq_vector_addr : req_addr;
  end
endmodule // vpbm_core_model

// ### testbench/testbench.sv
// self-checking bench for the vector priority and boot map block
`timescale 1ns/1ps
module testbench;
  import vpbm_pkg::*;
  logic sys_clk = 0, sys_rst = 1, e_b = 0, w_b = 0, sec = 0, wdt = 0, m_wr = 0, m_wd = 0, pins = 0, tv = 0;
  logic [1:0] mask = 0, ilvl;
  logic [20:0] vbr = 0, req = 0, fa, boot, vaddr, fphys;
  logic [21:0] pend = 0;
  logic [43:0] lvl = 0;
  logic valid, x20, fext, fblk, fhit;
  logic [4:0] vec;
  vpbm_mode_type mode;
  vpbm_map_type map;
  int failures = 0, n_tests = 0;
  vpbm_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .external_boot_strap(e_b), .address_width_strap(w_b),
    .flash_secure(sec), .watchdog_reset(wdt), .map_select_wr(m_wr), .map_select_wdata(m_wd),
    .upper_pins_enabled(pins), .vector_base_register(vbr), .irq_pending(pend), .irq_level_cfg(lvl),
    .core_mask_level(mask), .fetch_addr(fa), .boot_fetch_addr(boot), .irq_valid(valid), .irq_vector(vec),
    .irq_level(ilvl), .irq_vector_addr(vaddr), .mode_status(mode), .map_state(map), .ext_addr_20bit(x20),
    .fetch_external(fext), .fetch_blocked(fblk), .flash_phys_addr(fphys), .flash_hit(fhit));
  vpbm_core_model i_core (.sys_clk(sys_clk), .take_vec(tv), .irq_valid(valid), .irq_vector_addr(vaddr),
    .req_addr(req), .fetch_addr(fa));
  // clock and watchdog
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #50000;
    failures++;
    end_sim();
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset with given straps, then judge boot address and map
  task automatic t_boot(input logic [3:0] s, input logic [20:0] a, input vpbm_map_type m);
    {e_b, w_b, sec, wdt} = s;
    sys_rst = 1;
    step(2);
    sys_rst = 0;
    step(3);
    chk("boot_fetch_addr", boot, a);
    chk("map_state", 21'(map), 21'(m));
    chk("secured_state_bit", 21'(mode.secured_state_bit), 21'(s[1]));
    $display("boot test done");
  endtask
  // one ranking case: pending set, mask, expected winner and level
  task automatic irq(input logic [21:0] p, input logic [1:0] k, input logic [4:0] v, input logic [1:0] l);
    pend = p;
    mask = k;
    step(2);
    chk("irq_vector", 21'(vec), 21'(v));
    chk("irq_level", 21'(ilvl), 21'(l));
    chk("irq_vector_addr", vaddr, vbr + 21'(v) * 2);
  endtask
  task automatic t_prio();
    vbr = 21'h000100;
    lvl = 44'h300_0000_0000 | 44'h8_0000_0000 | 44'h4_0000;
    irq(22'h22_0200, 2'h0, 5'h11, 2'h2);
    lvl[19:18] = 2'h3;
    irq(22'h22_0200, 2'h0, 5'h09, 2'h3);
    irq(22'h22_0204, 2'h0, 5'h02, 2'h3);
    irq(22'h00_0040, 2'h0, 5'h06, 2'h1);
    irq(22'h10_0000, 2'h0, 5'h14, 2'h2);
    irq(22'h02_0000, 2'h3, 5'h00, 2'h0);
    chk("irq_valid", 21'(valid), 21'h0);
    pend = 0;
    $display("priority test done");
  endtask
  // software map write, then fetch decode in the new map
  task automatic t_map(input logic [20:0] exp);
    m_wd = 1;
    m_wr = 1;
    step(1);
    m_wr = 0;
    step(3);
    chk("map_select_bit", 21'(mode.map_select_bit), exp);
    req = 21'h010004;
    step(3);
    chk("flash_hit", 21'(fhit), exp);
    chk("flash_phys_addr", fphys, exp[0] ? 21'h000004 : 21'h000000);
    $display("map test done");
  endtask
  initial begin
    step(12);
    t_boot(4'h0, 21'h020000, VPBM_INT_MAP);
    t_boot(4'h1, 21'h020002, VPBM_INT_MAP);
    t_boot(4'h8, 21'h000000, VPBM_EXT16_MAP);
    t_boot(4'h9, 21'h000002, VPBM_EXT16_MAP);
    t_boot(4'hD, 21'h020002, VPBM_EXT20_MAP);
    t_boot(4'hE, 21'h020000, VPBM_INT_MAP);
    t_map(21'h0);
    t_boot(4'h0, 21'h020000, VPBM_INT_MAP);
    t_prio();
    t_map(21'h1);
    req = 21'h100000;
    step(3);
    chk("fetch_blocked", 21'(fblk), 21'h1);
    chk("fetch_external", 21'(fext), 21'h1);
    pins = 1;
    step(3);
    chk("fetch_blocked", 21'(fblk), 21'h0);
    $display("block test done");
    end_sim();
  end
endmodule // testbench
